// [src/lcs_pkg.sv]
// constants for the logic cell select and polarity block
package lcs_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 8;
   localparam int          SEL_W         = 6;
   localparam int          NUM_SRC       = 64;
   localparam logic [3:0]  OFS_POL       = 4'h0;
   localparam logic [3:0]  OFS_SEL1      = 4'h1;
   localparam logic [3:0]  OFS_SEL2      = 4'h2;
   localparam logic [3:0]  OFS_SEL3      = 4'h3;
   localparam logic [3:0]  OFS_CTRL      = 4'h4;
   localparam int          POL_OUT_BIT   = 7;
   localparam int          CTRL_EN_BIT   = 7;
   localparam int          CTRL_OUT_BIT  = 5;
   localparam logic [7:0]  POL_MASK      = 8'h8f;
   localparam logic [7:0]  SEL_MASK      = 8'h3f;
   localparam logic [7:0]  CTRL_WMASK    = 8'h87;
   localparam logic [7:0]  POL_RST       = 8'h00;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [5:0]  SEL_RST       = 6'h00;
   localparam logic [3:0]  GPOL_RST      = 4'h0;
   typedef enum logic [2:0] {
      LCS_AND_OR, LCS_OR_XOR, LCS_AND4, LCS_SR_LATCH,
      LCS_DFF_SR, LCS_DFF2_R, LCS_JK_R, LCS_LATCH_SR
   } lcs_mode_t;
endpackage : lcs_pkg

// [src/lcs_sel_mem.sv]
// small register file holding the three data selectors
`timescale 1ns/1ps
`default_nettype none
module lcs_sel_mem #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 3
) (
   input  wire logic                     clk,
   input  wire logic                     we,
   input  wire logic [1:0]               waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic [1:0]               raddr,
   output var  logic [WIDTH-1:0]         rdata_q,
   output var  logic [DEPTH*WIDTH-1:0]   all_q
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rdata_d;
   always_comb begin
      rdata_d = (int'(raddr) < DEPTH) ? mem_q[raddr] : '0;
      for (int i = 0; i < DEPTH; i++) begin
         all_q[i*WIDTH +: WIDTH] = mem_q[i];
      end
   end
   // contents are kept across every reset, no reset term on purpose
   always_ff @(posedge clk) begin
      if (we && int'(waddr) < DEPTH) begin
         mem_q[waddr] <= wdata;
      end
      rdata_q <= rdata_d;
   end
endmodule : lcs_sel_mem
`default_nettype wire

// [src/lcs_top.sv]
// polarity and input select registers with the cell function around them
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] output invert bit set inverts the cell result, clear passes it
// [R2] gate 3 invert bit inverts gate 3 before the logic function
// [R3] gate 2 invert bit inverts gate 2 before the logic function
// [R4] gate 1 invert bit inverts gate 1 before the logic function
// [R5] gate 0 invert bit inverts gate 0 before the logic function
// [R6] first selector is six read/write bits picking data input 1
// [R7] second selector is six read/write bits picking data input 2
// [R8] third selector is six read/write bits picking data input 3
// [R9] selector bits 7 and 6 ignore writes and read zero
// [R10] output invert clears on reset; gate bits and selectors keep value
// [R11] polarity bits 6 to 4 ignore writes and read zero
// [R12] three-bit function select picks one of eight logic functions
// [R13] disabled cell drives zero whatever its inputs
// [R14] output status bit reads the cell output after inversion
module lcs_top #(
   parameter int N_SRC = lcs_pkg::NUM_SRC
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [lcs_pkg::ADDR_W-1:0]  addr,
   input  wire logic [lcs_pkg::DATA_W-1:0]  wdata,
   input  wire logic                        wr,
   input  wire logic                        rd,
   output var  logic [lcs_pkg::DATA_W-1:0]  rdata_q,
   input  wire logic [N_SRC-1:0]            src_in,
   input  wire logic [3:0]                  gate_in,
   output var  logic [lcs_pkg::SEL_W-1:0]   data1_q,
   output var  logic [lcs_pkg::SEL_W-1:0]   data2_q,
   output var  logic [lcs_pkg::SEL_W-1:0]   data3_q,
   output var  logic [2:0]                  data_sig_q,
   output var  logic [3:0]                  gate_pol_q,
   output var  logic                        cell_output_signal_q
);
   import lcs_pkg::*;

   function automatic logic pick(input logic [N_SRC-1:0] v,
                                 input logic [SEL_W-1:0] s);
      pick = (int'(s) < N_SRC) ? v[s] : 1'b0;
   endfunction : pick

   // one selector field out of the flat copy, by register address
   function automatic logic [SEL_W-1:0] sel_field(
         input logic [3*SEL_W-1:0] flat,
         input logic [1:0]         idx);
      if (idx == 2'd1) begin
         sel_field = flat[0 +: SEL_W];
      end else if (idx == 2'd2) begin
         sel_field = flat[SEL_W +: SEL_W];
      end else begin
         sel_field = flat[2*SEL_W +: SEL_W];
      end
   endfunction : sel_field

   logic [3:0]  gpol_q, gpol_d;
   logic        oinv_q, oinv_d;
   logic [7:0]  ctrl_q, ctrl_d;
   logic        st_q, st_d;
   logic        out_q, out_d;
   logic [7:0]  rdata_d;
   logic [2:0]  dsig_d;
   logic [3:0]  g;
   logic        f;
   logic [3*SEL_W-1:0] sel_all;
   logic        sel_we;
   logic [1:0]  sel_wa;
   lcs_mode_t   mode;

   always_comb begin
      sel_we = wr && (addr == OFS_SEL1 || addr == OFS_SEL2 ||
                      addr == OFS_SEL3);                          // [R6]
      sel_wa = addr[1:0] - 2'd1;
   end

   lcs_sel_mem #(.WIDTH(SEL_W), .DEPTH(3)) u_sel (
      .clk     (clk),
      .we      (sel_we),
      .waddr   (sel_wa),
      .wdata   (wdata[SEL_W-1:0]),                                // [R9]
      .raddr   (addr[1:0] - 2'd1),
      .rdata_q (),
      .all_q   (sel_all)
   );

   // register writes
   always_comb begin
      gpol_d = gpol_q;
      oinv_d = oinv_q;
      ctrl_d = ctrl_q;
      if (wr && addr == OFS_POL) begin
         oinv_d = wdata[POL_OUT_BIT];                            // [R1]
         gpol_d = wdata[3:0];                                   // [R11]
      end else if (wr && addr == OFS_CTRL) begin
         ctrl_d = wdata & CTRL_WMASK;
      end
      if (!rst_n) begin
         oinv_d = POL_RST[POL_OUT_BIT];                          // [R10]
         ctrl_d = CTRL_RST;
      end
   end

   // gate polarity is not reset, as with the selectors
   always_ff @(posedge clk) begin
      gpol_q <= gpol_d;                                          // [R10]
   end

   always_ff @(posedge clk) begin
      oinv_q <= oinv_d;
      ctrl_q <= ctrl_d;
   end

   // gate outputs after their own invert bits
   always_comb begin
      g[0] = gate_in[0] ^ gpol_q[0];                             // [R5]
      g[1] = gate_in[1] ^ gpol_q[1];                             // [R4]
      g[2] = gate_in[2] ^ gpol_q[2];                             // [R3]
      g[3] = gate_in[3] ^ gpol_q[3];                             // [R2]
   end

   // cell function; the storage modes step on the system clock
   always_comb begin
      mode = lcs_mode_t'(ctrl_q[2:0]);
      st_d = st_q;
      f    = 1'b0;
      case (mode)                                                // [R12]
         LCS_AND_OR:   f = (g[0] & g[1]) | (g[2] & g[3]);
         LCS_OR_XOR:   f = (g[0] | g[1]) ^ (g[2] | g[3]);
         LCS_AND4:     f = &g;
         // set from gates 0 or 1, reset from gates 2 or 3, set wins
         LCS_SR_LATCH: begin
            if (g[0] | g[1]) st_d = 1'b1;
            else if (g[2] | g[3]) st_d = 1'b0;
            f = st_d;
         end
         // reset gate 2, set gate 0, data gate 1
         LCS_DFF_SR: begin
            if (g[2]) st_d = 1'b0;
            else if (g[0]) st_d = 1'b1;
            else st_d = g[1];
            f = st_d;
         end
         // reset gate 2, data is gates 1 and 3 together
         LCS_DFF2_R: begin
            if (g[2]) st_d = 1'b0;
            else st_d = g[1] & g[3];
            f = st_d;
         end
         // reset gate 2, j from gate 1, k from gate 3
         LCS_JK_R: begin
            if (g[2]) st_d = 1'b0;
            else if (g[1] & g[3]) st_d = ~st_q;
            else if (g[1]) st_d = 1'b1;
            else if (g[3]) st_d = 1'b0;
            f = st_d;
         end
         // reset gate 3, set gate 0, gate 1 passes while gate 2 is low
         default: begin
            if (g[3]) st_d = 1'b0;
            else if (g[0]) st_d = 1'b1;
            else if (!g[2]) st_d = g[1];
            f = st_d;
         end
      endcase
      if (!ctrl_q[CTRL_EN_BIT]) begin
         st_d = 1'b0;                                            // [R13]
      end
      if (!rst_n) begin
         st_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   // output invert after the function, held low while disabled
   always_comb begin
      out_d = 1'b0;                                              // [R13]
      if (rst_n && ctrl_q[CTRL_EN_BIT]) begin
         out_d = f ^ oinv_q;                                     // [R1]
      end
   end

   always_ff @(posedge clk) begin
      out_q                <= out_d;
      cell_output_signal_q <= out_d;
   end

   // selected sources and selector copies toward the gate logic
   always_comb begin
      dsig_d = {pick(src_in, sel_field(sel_all, 2'd3)),          // [R8]
                pick(src_in, sel_field(sel_all, 2'd2)),          // [R7]
                pick(src_in, sel_field(sel_all, 2'd1))};         // [R6]
   end

   always_ff @(posedge clk) begin
      data_sig_q <= dsig_d;
      data1_q    <= sel_field(sel_all, 2'd1);                    // [R6]
      data2_q    <= sel_field(sel_all, 2'd2);                    // [R7]
      data3_q    <= sel_field(sel_all, 2'd3);                    // [R8]
      gate_pol_q <= gpol_d;
   end

   // read data registered at the strobe, zero in every other cycle
   always_comb begin
      rdata_d = '0;
      if (rd && rst_n) begin
         if (addr == OFS_POL) begin
            rdata_d = {oinv_q, 3'b000, gpol_q} & POL_MASK;       // [R11]
         end else if (addr == OFS_SEL1 || addr == OFS_SEL2 ||
                      addr == OFS_SEL3) begin
            rdata_d = {2'b00, sel_field(sel_all, addr[1:0])};
            rdata_d = rdata_d & SEL_MASK;                        // [R9]
         end else if (addr == OFS_CTRL) begin
            rdata_d = ctrl_q;
            rdata_d[CTRL_OUT_BIT] = out_q;                       // [R14]
         end
      end
   end

   always_ff @(posedge clk) begin
      rdata_q <= rdata_d;
   end
endmodule : lcs_top
`default_nettype wire

// [verif/lcs_props.sv]
// port assertions for the select and polarity block
`timescale 1ns/1ps
`default_nettype none
module lcs_props (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata_q,
   input wire logic [5:0] data1_q,
   input wire logic       cell_output_signal_q
);
   logic en_q;
   logic en_d;
   // shadow of the cell enable bit
   always_comb en_d = (wr && addr == 4'h4) ? wdata[7] : en_q;
   always_ff @(posedge clk) en_q <= rst_n ? en_d : 1'b0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence wr_rd(lo, hi);
      wr && addr >= lo && addr <= hi ##1 rd && addr == $past(addr);
   endsequence
   sel_unimp_a: assert property (
      rd && addr >= 4'h1 && addr <= 4'h3 |=> rdata_q[7:6] == 2'b00)
      else $error("selector top bits not zero");
   pol_unimp_a: assert property (
      rd && addr == 4'h0 |=> rdata_q[6:4] == 3'b000)
      else $error("polarity bits 6 to 4 not zero");
   sel_back_a: assert property (
      wr_rd(4'h1, 4'h3) |=> rdata_q == {2'b00, $past(wdata[5:0], 2)})
      else $error("selector readback wrong");
   pol_back_a: assert property (
      wr_rd(4'h0, 4'h0) |=> rdata_q == ($past(wdata, 2) & 8'h8f))
      else $error("polarity readback wrong");
   sel_out_a: assert property (
      wr && addr == 4'h1 |-> ##2 data1_q == $past(wdata[5:0], 2))
      else $error("data 1 selector output wrong");
   dis_zero_a: assert property (
      !en_q |=> !cell_output_signal_q)
      else $error("disabled cell output not zero");
   status_bit_a: assert property (
      rd && addr == 4'h4 |=> rdata_q[5] == $past(cell_output_signal_q))
      else $error("status bit differs from output");
   idle_zero_a: assert property (!rd |=> rdata_q == 8'h00)
      else $error("read data not zero when idle");
endmodule : lcs_props
bind lcs_top lcs_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .data1_q(data1_q),
   .cell_output_signal_q(cell_output_signal_q));
`default_nettype wire

// [verif/lcs_top_tb.sv]
// self-checking bench for the select and polarity block
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb;
   import lcs_pkg::*;
   logic        clk, rst_n, wr, rd, out, e, st, st2;
   logic [3:0]  addr, gi, gp, a, g, x;
   logic [7:0]  wdata, rdata, d, v;
   logic [7:0]  m [4];
   logic [63:0] src;
   logic [5:0]  s1, s2, s3;
   logic [2:0]  dsig, mo;
   logic [31:0] seed = 32'h0000_fbe4;
   int          n_fail = 0, total_checks = 0, cyc = 0, i;
   lcs_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_q(rdata), .src_in(src), .gate_in(gi),
      .data1_q(s1), .data2_q(s2), .data3_q(s3), .data_sig_q(dsig),
      .gate_pol_q(gp), .cell_output_signal_q(out));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // model of one cell step: next state, or the result of a plain mode
   function automatic logic cell_f(input logic [2:0] md,
                                   input logic [3:0] x, input logic s);
      case (md)
         3'd0: return (x[0] & x[1]) | (x[2] & x[3]);
         3'd1: return (x[0] | x[1]) ^ (x[2] | x[3]);
         3'd2: return &x;
         3'd3: return (x[0] | x[1]) ? 1'b1 : (x[2] | x[3]) ? 1'b0 : s;
         3'd4: return x[2] ? 1'b0 : x[0] ? 1'b1 : x[1];
         3'd5: return x[2] ? 1'b0 : x[1] & x[3];
         3'd6: return x[2] ? 1'b0 : (x[1] & x[3]) ? !s
                    : x[1] ? 1'b1 : x[3] ? 1'b0 : s;
         default: return x[3] ? 1'b0 : x[0] ? 1'b1 : !x[2] ? x[1] : s;
      endcase
   endfunction : cell_f
   task automatic chk(input logic [7:0] gv, input logic [7:0] ev);
      total_checks++;
      if (gv !== ev) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
      end
   endtask : chk
   task automatic wr_t(input logic [3:0] ad, input logic [7:0] dv);
      addr <= ad;
      wdata <= dv;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask : wr_t
   task automatic rd_t(input logic [3:0] ad, output logic [7:0] dv);
      addr <= ad;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 dv = rdata;
      @(posedge clk);
   endtask : rd_t
   task automatic test_done();
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      {addr, wdata, wr, rd, src, gi} = '0;
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd_t(4'h0, d);
      chk(d & 8'h80, 8'h00);
      for (i = 0; i < 20; i++) begin
         a = (i % 5 == 4) ? 4'h9 : 4'(i % 5);
         v = 8'(xs());
         wr_t(a, v);
         if (a < 4) m[a] = v & (a == 0 ? 8'h8f : 8'h3f);
         rd_t(a, d);
         chk(d, a < 4 ? m[a] : 8'h00);
      end
      src <= {xs(), xs()};
      repeat (3) @(posedge clk);
      #1 chk(8'(dsig), 8'({src[m[3][5:0]], src[m[2][5:0]],
                           src[m[1][5:0]]}));
      chk({2'b00, s1}, m[1]);
      chk({2'b00, s2}, m[2]);
      chk({2'b00, s3}, m[3]);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      m[0][7] = 1'b0;
      for (i = 0; i < 4; i++) begin
         rd_t(4'(i), d);
         chk(d, m[i]);
      end
      // disable first so the cell state starts from zero, then write the mode with enable set unless the step number is a multiple of three
      for (i = 0; i < 24; i++) begin
         v  = 8'(xs());
         g  = 4'(xs());
         mo = 3'(i % 8);
         e  = (i % 3) != 0;
         gi <= g;
         wr_t(OFS_CTRL, 8'h00);
         wr_t(OFS_POL, v);
         wr_t(OFS_CTRL, {e, 4'h0, mo});
         rd_t(OFS_SEL1, d);
         chk(d, m[1]);
         rd_t(OFS_CTRL, d);
         x   = g ^ v[3:0];
         st  = cell_f(mo, x, 1'b0);
         st2 = cell_f(mo, x, st);
         st  = cell_f(mo, x, st2);
         chk(8'(out), 8'(e & (st ^ v[7])));
         chk(8'(d[5]), 8'(e & (st2 ^ v[7])));
         chk(8'(gp), 8'(v[3:0]));
         chk(d & 8'h87, {e, 4'h0, mo});
      end
      test_done();
   end
endmodule : lcs_top_tb
`default_nettype wire
